// ==== board_pin_model.sv ====
// board controller model driving reset, power-down, supply and strap pins
// assumes the bench calls its tasks between clock edges
module board_pin_model (
    // clock
    input wire logic hclk,
    // pins towards the block
    output logic reset_pin_n,
    output logic power_down_input,
    output logic supply_low_fault,
    output logic [8:0] straps
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reset_pin_n = 1'b1;
        power_down_input = 1'b0;
        supply_low_fault = 1'b0;
        straps = 9'h0A5;
    end
    // hold the reset pin low for n whole clocks, two being the least taken
    task automatic pulse_reset(input int n);
        @(posedge hclk);
        reset_pin_n <= 1'b0;
        repeat (n) @(posedge hclk);
        reset_pin_n <= 1'b1;
    endtask : pulse_reset
    // levels change just after an edge, like a real board controller
    task automatic set_pins(input logic pd, input logic lv, input logic [8:0] s);
        @(posedge hclk);
        power_down_input <= pd;
        supply_low_fault <= lv;
        straps <= s;
    endtask : set_pins
endmodule : board_pin_model

// ==== phy_reset_power_control.sv ====
// reset, power-down and supply-fault controller of a 10/100 transceiver
// assumes hclk at 100 MHz, AHB-Lite slave, pins asynchronous to hclk
//
// Added by the designer: register access over AHB-Lite and the register addresses.
`include "phy_rst_defines.svh"
module phy_reset_power_control
    import phy_rst_pkg::*;
#(
    parameter int EXT_CYCLES = `EXT_RESET_CYCLES
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // board pins
    input wire logic reset_pin_n,
    input wire logic power_down_input,
    input wire logic supply_low_fault,
    input wire logic [4:0] multi_function_config_pins,
    input wire logic full_duplex_enable_pin,
    input wire logic config_pin_zero,
    input wire logic config_pin_one,
    // block controls
    output logic transmit_enable,
    output logic core_reset_n,
    output logic core_powered,
    output logic mgmt_data_oe,
    output logic [8:0] active_config,
    output logic irq
);
    //********************************
    // pin synchronisation
    //********************************
    logic [10:0] pins_s; // synchronised pin levels
    pin_sync #(.WIDTH(11)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in({reset_pin_n, power_down_input, supply_low_fault, config_pin_one, config_pin_zero,
                 full_duplex_enable_pin, multi_function_config_pins}),
        .pin_out(pins_s)
    );
    logic rst_pin_s;
    logic pdn_s;
    logic low_s;
    logic [8:0] cfg_s;
    assign rst_pin_s = pins_s[10];
    assign pdn_s = pins_s[9];
    assign low_s = pins_s[8];
    // eight strap pins; the top bit of the latched word is spare and reads zero
    assign cfg_s = {1'b0, pins_s[7:0]};

    //********************************
    // reset sequencer
    //********************************
    seq_state_t st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt; // extension / soft reset counter
    logic [1:0] low_cnt_r, low_cnt_nxt; // clocks seen with reset pin low
    logic [8:0] cfg_r, cfg_nxt; // latched configuration
    logic done_ev; // soft reset completion pulse
    logic soft_req; // soft reset written by software

    // a short glitch on the reset pin is ignored; only two clean lows count
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        cfg_nxt = cfg_r;
        done_ev = 1'b0;
        low_cnt_nxt = rst_pin_s ? 2'h0 : ((low_cnt_r == 2'h3) ? low_cnt_r : low_cnt_r + 2'h1);
        if (low_cnt_nxt >= 2'(`HW_RESET_MIN_CYCLES)) begin
            st_nxt = ST_HW_HOLD;
            cnt_nxt = '0;
        end else begin
            case (st_r)
                ST_HW_HOLD: begin
                    if (rst_pin_s) begin
                        st_nxt = ST_EXTEND;
                        cfg_nxt = cfg_s;
                        cnt_nxt = '0;
                    end
                end
                ST_EXTEND: begin
                    if (cnt_r >= 32'(EXT_CYCLES - 1)) begin
                        st_nxt = ST_RUN;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 32'h1;
                    end
                end
                ST_RUN: begin
                    if (soft_req) begin
                        st_nxt = ST_SOFT;
                        cnt_nxt = '0;
                    end
                end
                ST_SOFT: begin
                    if (cnt_r >= 32'(`SOFT_RESET_CYCLES - 1)) begin
                        st_nxt = ST_RUN;
                        cfg_nxt = cfg_s;
                        done_ev = 1'b1;
                        cnt_nxt = '0;
                    end else begin
                        cnt_nxt = cnt_r + 32'h1;
                    end
                end
                default: begin
                    st_nxt = ST_HW_HOLD;
                end
            endcase
        end
    end

    // sequencer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= ST_HW_HOLD;
            cnt_r <= '0;
            low_cnt_r <= 2'h0;
            cfg_r <= 9'h000;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            low_cnt_r <= low_cnt_nxt;
            cfg_r <= cfg_nxt;
        end
    end

    logic bus_open; // registers reachable only in run or soft reset
    assign bus_open = (st_r == ST_RUN) || (st_r == ST_SOFT);

    //********************************
    // ahb-lite slave
    //********************************
    logic ph_act_r, ph_act_nxt; // data phase pending
    logic ph_wr_r, ph_wr_nxt;
    logic [11:0] ph_addr_r, ph_addr_nxt;
    logic [15:0] ctrl_r, ctrl_nxt; // control register, bit 15 soft reset
    logic [1:0] ists_r, ists_nxt; // sticky interrupt status
    logic [1:0] imask_r, imask_nxt;
    logic [31:0] rdata_nxt;
    logic irq_nxt;
    logic lv_prev_r; // low-voltage level last cycle, for edge event
    logic wr_go;

    // data phase completes every cycle; bus is refused while closed
    always_comb begin
        ph_act_nxt = hsel && hready && htrans[1] && bus_open;
        ph_wr_nxt = hwrite;
        ph_addr_nxt = haddr;
        wr_go = ph_act_r && ph_wr_r && bus_open;
        soft_req = 1'b0;
        ctrl_nxt = ctrl_r; // power-down leaves these untouched
        ists_nxt = ists_r;
        imask_nxt = imask_r;
        if (wr_go) begin
            case (ph_addr_r)
                `OFS_CONTROL: begin
                    ctrl_nxt = hwdata[15:0];
                    if (st_r == ST_SOFT) begin
                        ctrl_nxt[`CTRL_SOFT_RESET_BIT] = 1'b1;
                    end
                    soft_req = hwdata[`CTRL_SOFT_RESET_BIT];
                end
                `OFS_IRQ_STATUS: ists_nxt = ists_r & ~hwdata[1:0];
                `OFS_IRQ_MASK: imask_nxt = hwdata[1:0];
                default: ;
            endcase
        end
        // soft reset clears control and self-clears the bit
        if (done_ev) begin
            ctrl_nxt = `CONTROL_RESET;
        end
        if (st_r == ST_HW_HOLD) begin
            ctrl_nxt = `CONTROL_RESET;
        end
        // set wins over clear
        if (low_s && !lv_prev_r) begin
            ists_nxt[`IRQ_LOW_VOLT_BIT] = 1'b1;
        end
        if (done_ev) begin
            ists_nxt[`IRQ_RESET_DONE_BIT] = 1'b1;
        end
        rdata_nxt = 32'h0000_0000;
        if (ph_act_nxt && !hwrite) begin
            case (haddr)
                `OFS_CONTROL: rdata_nxt = {16'h0000, ctrl_nxt};
                `OFS_FAULT_STATUS: rdata_nxt = {29'h0, low_s, 2'h0};
                `OFS_IRQ_STATUS: rdata_nxt = {30'h0, ists_nxt};
                `OFS_IRQ_MASK: rdata_nxt = {30'h0, imask_nxt};
                `OFS_CONFIG: rdata_nxt = {23'h0, cfg_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(ists_nxt & imask_nxt);
    end

    // bus and register flops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_act_r <= 1'b0;
            ph_wr_r <= 1'b0;
            ph_addr_r <= 12'h000;
            ctrl_r <= `CONTROL_RESET;
            ists_r <= 2'h0;
            imask_r <= `IRQ_MASK_RESET;
            hrdata <= 32'h0000_0000;
            irq <= 1'b0;
            lv_prev_r <= 1'b0;
        end else begin
            ph_act_r <= ph_act_nxt;
            ph_wr_r <= ph_wr_nxt;
            ph_addr_r <= ph_addr_nxt;
            ctrl_r <= ctrl_nxt;
            ists_r <= ists_nxt;
            imask_r <= imask_nxt;
            hrdata <= rdata_nxt;
            irq <= irq_nxt;
            lv_prev_r <= low_s;
        end
    end

    //********************************
    // core controls
    //********************************
    // all outputs registered; hreadyout low in reset and high after it, response always okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            transmit_enable <= 1'b0;
            core_reset_n <= 1'b0;
            core_powered <= 1'b0;
            mgmt_data_oe <= 1'b0;
            active_config <= 9'h000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            transmit_enable <= (st_nxt == ST_RUN) && !low_s && !pdn_s;
            core_reset_n <= (st_nxt == ST_RUN);
            core_powered <= !pdn_s;
            mgmt_data_oe <= bus_open;
            active_config <= cfg_nxt;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule : phy_reset_power_control

// ==== phy_rst_checker.sv ====
// port assertions for the reset, power-down and supply-fault controller
// assumes hready is looped back from hreadyout and one clock domain
module phy_rst_checker
    import phy_rst_pkg::*;
#(
    parameter int EXT_CYCLES = 20
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answers
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // board pins
    input wire logic reset_pin_n,
    input wire logic power_down_input,
    input wire logic supply_low_fault,
    input wire logic [4:0] multi_function_config_pins,
    input wire logic full_duplex_enable_pin,
    input wire logic config_pin_zero,
    input wire logic config_pin_one,
    // block controls
    input wire logic transmit_enable,
    input wire logic core_reset_n,
    input wire logic core_powered,
    input wire logic mgmt_data_oe,
    input wire logic [8:0] active_config
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles since the reset pin let go, frozen once management opens
    int unsigned ext_cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn || !reset_pin_n) ext_cnt <= 0;
        else if (!mgmt_data_oe) ext_cnt <= ext_cnt + 1;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // the pin synchroniser adds latency, so faults are held four clocks
    sequence lowv_held; supply_low_fault [*4]; endsequence
    // a pin reset also drops the core with management still open; the pin low two clocks before tells it apart for pin pulses of three clocks or more
    sequence soft_start; $fell(core_reset_n) && mgmt_data_oe && $past(reset_pin_n, 2); endsequence
    sequence soft_hold; !core_reset_n [*8] ##[1:20] core_reset_n; endsequence
    chk_lowv_gate: assert property (lowv_held |-> !transmit_enable)
        else $error("transmit on during low supply");
    chk_tx_resume: assert property ((core_reset_n && !power_down_input && !supply_low_fault) [*4] |-> transmit_enable)
        else $error("transmit not restored");
    chk_pd_off: assert property (power_down_input [*4] |-> !core_powered && !transmit_enable)
        else $error("function alive in power down");
    chk_pd_mgmt: assert property (power_down_input && mgmt_data_oe |=> mgmt_data_oe)
        else $error("management lost in power down");
    chk_bus_ok: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus stalled or erred");
    chk_reset_quiet: assert property (!core_reset_n |-> !transmit_enable)
        else $error("transmit on in reset");
    chk_soft_seq: assert property (soft_start |-> soft_hold)
        else $error("soft reset length wrong");
    chk_cfg_load: assert property ($rose(mgmt_data_oe) |-> active_config == {config_pin_one, config_pin_zero,
        full_duplex_enable_pin, multi_function_config_pins})
        else $error("config not taken from pins");
    chk_ext_len: assert property ($rose(mgmt_data_oe) |-> ext_cnt >= EXT_CYCLES && ext_cnt <= EXT_CYCLES + 6)
        else $error("internal reset length wrong");
    chk_ext_refuse: assert property (!mgmt_data_oe |=> hrdata == 32'h0)
        else $error("read data during internal reset");
endmodule : phy_rst_checker
bind phy_reset_power_control phy_rst_checker #(.EXT_CYCLES(EXT_CYCLES)) u_chk (.hclk, .hresetn, .hrdata,
    .hreadyout, .hresp, .reset_pin_n, .power_down_input, .supply_low_fault, .multi_function_config_pins,
    .full_duplex_enable_pin, .config_pin_zero, .config_pin_one, .transmit_enable, .core_reset_n,
    .core_powered, .mgmt_data_oe, .active_config);

// ==== phy_rst_defines.svh ====
// constants for the phy reset / power-down / supply-fault controller
// assumes a 100 MHz hclk and an AHB-Lite register bus with word registers
`ifndef PHY_RST_DEFINES_SVH
`define PHY_RST_DEFINES_SVH

// register byte offsets
`define OFS_CONTROL 12'h000
`define OFS_FAULT_STATUS 12'h050
`define OFS_IRQ_STATUS 12'h060
`define OFS_IRQ_MASK 12'h064
`define OFS_CONFIG 12'h068

// control register fields
`define CTRL_SOFT_RESET_BIT 15
// fault status register fields
`define FAULT_LOW_VOLT_BIT 2
// interrupt bit positions
`define IRQ_LOW_VOLT_BIT 0
`define IRQ_RESET_DONE_BIT 1
`define IRQ_WIDTH 2

// reset values
`define CONTROL_RESET 16'h0000
`define IRQ_MASK_RESET 2'h0

// timing
`define CLK_PERIOD_NS 10
`define EXT_RESET_US 300
`define EXT_RESET_CYCLES ((`EXT_RESET_US * 1000) / `CLK_PERIOD_NS)
`define HW_RESET_MIN_CYCLES 2
`define SOFT_RESET_CYCLES 16

`endif

// ==== phy_rst_pkg.sv ====
// types shared by the reset controller files
// assumes the defines header is compiled first
package phy_rst_pkg;
    // reset sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_HW_HOLD = 4'h1,
        ST_EXTEND = 4'h2,
        ST_RUN = 4'h4,
        ST_SOFT = 4'h8
    } seq_state_t;
endpackage : phy_rst_pkg

// ==== pin_sync.sv ====
// two-flop synchroniser for a bus of asynchronous pin levels
// assumes the pins are quasi-static levels
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_r; // first stage, read only by second stage
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // next values: plain shift
    always_comb begin
        meta_nxt = pin_in;
        sync_nxt = meta_r;
    end

    // register the chain
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_out = sync_r;
endmodule : pin_sync

// ==== tb_phy_reset_power_control.sv ====
// self-checking bench of the reset, power-down and supply-fault controller
// assumes one bus master and the board model on the pins
`include "phy_rst_defines.svh"
module tb_phy_reset_power_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EXT = 20;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, rst_n, pd, lv, tx, core_n, pwr, oe, irq;
    logic [8:0] st, cfg;
    logic [15:0] lfsr = 16'h2C40;
    int num_errors = 0, total_checks = 0, cyc = 0, t0, mask_m;
    always #5 hclk = ~hclk;
    board_pin_model brd (.hclk(hclk), .reset_pin_n(rst_n), .power_down_input(pd), .supply_low_fault(lv),
        .straps(st));
    phy_reset_power_control #(.EXT_CYCLES(EXT)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .reset_pin_n(rst_n), .power_down_input(pd),
        .supply_low_fault(lv), .multi_function_config_pins(st[4:0]), .full_duplex_enable_pin(st[5]),
        .config_pin_zero(st[6]), .config_pin_one(st[7]), .transmit_enable(tx), .core_reset_n(core_n),
        .core_powered(pwr), .mgmt_data_oe(oe), .active_config(cfg), .irq(irq));
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one single word transfer; waits on hready in both phases
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 4000) begin
            num_errors++;
            end_of_test();
        end
    end
    // low supply, then clear it; mask decides whether irq follows
    task automatic lowv(input int m);
        bus(1, `OFS_IRQ_MASK, m);
        brd.set_pins(0, 1, st);
        while (tx !== 1'b0) @(posedge hclk);
        bus(0, `OFS_FAULT_STATUS, 0);
        chk("fault flag", 32'h4, rd);
        chk("irq", m & 1, irq);
        brd.set_pins(0, 0, st);
        while (tx !== 1'b1) @(posedge hclk);
        bus(0, `OFS_FAULT_STATUS, 0);
        chk("fault clear", 0, rd);
        bus(0, `OFS_IRQ_STATUS, 0);
        chk("sticky", 1, rd[0]);
        bus(1, `OFS_IRQ_STATUS, 1);
        @(posedge hclk);
        chk("irq clear", 0, irq);
    endtask : lowv
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t0 = cyc;
        bus(0, `OFS_CONFIG, 0);
        chk("refused read", 0, rd);
        while (oe !== 1'b1) @(posedge hclk);
        chk("ext len", 1, cyc - t0 >= EXT && cyc - t0 <= EXT + 8);
        chk("cfg pins", {1'b0, st[7:0]}, cfg);
        bus(0, `OFS_CONFIG, 0);
        chk("cfg reg", {1'b0, st[7:0]}, rd);
        bus(0, 12'h100, 0);
        chk("unmapped", 0, rd);
        lowv(3);
        lowv(2);
        mask_m = 2;
        brd.set_pins(1, 0, st);
        while (pwr !== 1'b0) @(posedge hclk);
        chk("pd tx", 0, tx);
        bus(0, `OFS_IRQ_MASK, 0);
        chk("pd mgmt", mask_m, rd);
        brd.set_pins(0, 0, st);
        while (pwr !== 1'b1) @(posedge hclk);
        bus(0, `OFS_IRQ_MASK, 0);
        chk("mask kept", mask_m, rd);
        lfsr = nxt(lfsr);
        brd.set_pins(0, 0, lfsr[8:0]);
        bus(1, `OFS_CONTROL, 32'h8000);
        bus(0, `OFS_CONTROL, 0);
        chk("soft bit", 32'h8000, rd);
        chk("soft core", 0, core_n);
        repeat (20) if (rd[15] !== 1'b0) bus(0, `OFS_CONTROL, 0);
        chk("soft done", 0, rd);
        bus(0, `OFS_CONFIG, 0);
        chk("soft cfg", {1'b0, st[7:0]}, rd);
        bus(0, `OFS_IRQ_STATUS, 0);
        chk("done irq", 1, rd[1]);
        chk("done irq line", 1, irq);
        lfsr = nxt(lfsr);
        brd.set_pins(0, 0, lfsr[8:0]);
        brd.pulse_reset(2);
        while (oe !== 1'b0) @(posedge hclk);
        while (oe !== 1'b1) @(posedge hclk);
        chk("hw cfg", {1'b0, st[7:0]}, cfg);
        end_of_test();
    end
endmodule : tb_phy_reset_power_control
